/* common/ssmc_pkg.sv */
// ssmc_pkg: constants, states and carrier types of the low power mode
// controller. Assumes a 10-bit data-space address and 4-bit data words.
package ssmc_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned NIB_W  = 4;
	localparam int unsigned IRQ_N  = 7;

	// ------------------------------------------------------------------
	// register map and field layout
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RAM_FLAG  = 10'h021;
	localparam logic [ADDR_W-1:0] ADDR_PORT_FUNC = 10'h024;
	localparam int unsigned       RAM_FLAG_BIT   = 3;
	localparam int unsigned       WAKE_SEL_BIT   = 3;

	// ------------------------------------------------------------------
	// reset values and bit groups
	// ------------------------------------------------------------------
	localparam logic [NIB_W-1:0] PORT_FUNC_RST     = 4'h0;
	localparam logic [NIB_W-1:0] PORT_FUNC_KEEP    = 4'h8; // survives stop
	localparam logic [NIB_W-1:0] PORT_FUNC_FULL    = 4'hF; // 4-bit variant
	localparam logic [NIB_W-1:0] PORT_FUNC_REDUCED = 4'h9; // 2-bit variant
	localparam logic [NIB_W-1:0] RDATA_ZERO        = 4'h0;
	localparam logic             RAM_FLAG_RST      = 1'b0;
	localparam logic             PIN_IDLE          = 1'b1;
	localparam logic [2:0]       SYNC_RST          = 3'h7;

	// ------------------------------------------------------------------
	// operating states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_ACTIVE   = 3'b000,
		ST_STANDBY  = 3'b001,
		ST_STOP     = 3'b010,
		ST_STOP_REL = 3'b011,
		ST_RST      = 3'b100,
		ST_RST_KEEP = 3'b101
	} ssmc_state_t;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [NIB_W-1:0]  wdata;
		logic [NIB_W-1:0]  wmask;
	} ssmc_reg_req_t;

	typedef struct packed {
		logic [IRQ_N-1:0] flag;
		logic [IRQ_N-1:0] mask;
		logic             global_en;
	} ssmc_irq_t;

	typedef struct packed {
		logic osc_en;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic cpu_rst;
		logic periph_rst;
		logic port_hiz;
		logic port_hold;
		logic ram_retain;
	} ssmc_pwr_t;

endpackage

/* rtl/ssmc_regs.sv */
// ssmc_regs: port function select and ram retained flag, with read port.
// Assumes bit-manipulation writes carry a per-bit mask.
`timescale 1ns/1ns
module ssmc_regs (
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic                     ce_i,
	input  wire logic                     reduced_i,
	input  wire ssmc_pkg::ssmc_reg_req_t  req_i,
	input  wire logic                     stop_entry_i,
	input  wire logic                     flag_set_i,
	output logic [ssmc_pkg::NIB_W-1:0]    port_func_o,
	output logic                          ram_flag_o,
	output logic [ssmc_pkg::NIB_W-1:0]    rdata_o
);
	import ssmc_pkg::*;

	logic [NIB_W-1:0] pf_q;
	logic [NIB_W-1:0] impl;
	logic             flag_q;
	logic             hit_flag;
	logic             hit_pf;

	assign impl     = reduced_i ? PORT_FUNC_REDUCED : PORT_FUNC_FULL;
	assign hit_flag = req_i.addr == ADDR_RAM_FLAG;
	assign hit_pf   = req_i.addr == ADDR_PORT_FUNC;

	// port function select: stop clears all but the wake select bit
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (!rstn_i) begin
				pf_q <= PORT_FUNC_RST;
			end else if (stop_entry_i) begin
				pf_q <= pf_q & PORT_FUNC_KEEP;
			end else if (req_i.wr && hit_pf) begin
				pf_q <= ((pf_q & ~req_i.wmask) | (req_i.wdata & req_i.wmask))
					& impl;
			end
		end
	end

	// ram retained flag: set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (!rstn_i) begin
				flag_q <= RAM_FLAG_RST;
			end else if (flag_set_i) begin
				flag_q <= 1'b1;
			end else if (req_i.wr && hit_flag && req_i.wmask[RAM_FLAG_BIT]
				&& !req_i.wdata[RAM_FLAG_BIT]) begin
				flag_q <= 1'b0;
			end
		end
	end

	// read data; port function register is write-only and reads zero
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (!rstn_i) begin
				rdata_o <= RDATA_ZERO;
			end else if (req_i.rd && hit_flag) begin
				rdata_o <= RDATA_ZERO | (NIB_W'(flag_q) << RAM_FLAG_BIT);
			end else begin
				rdata_o <= RDATA_ZERO;
			end
		end
	end

	assign port_func_o = pf_q;
	assign ram_flag_o  = flag_q;

endmodule // ssmc_regs

/* rtl/ssmc_sync.sv */
// ssmc_sync: three-stage synchroniser for a pad input with agreement
// filter. Assumes the pad is asynchronous to the system clock.
`timescale 1ns/1ns
module ssmc_sync (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	output logic      pin_o
);
	import ssmc_pkg::*;

	logic [2:0] stage_q;
	logic       level_q;

	// three flops; stage 0 feeds only stage 1
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (!rstn_i) begin
				stage_q <= SYNC_RST;
			end else begin
				stage_q <= {stage_q[1:0], pin_i};
			end
		end
	end

	// level changes once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (!rstn_i) begin
				level_q <= PIN_IDLE;
			end else if (stage_q[1] == stage_q[2]) begin
				level_q <= stage_q[2];
			end
		end
	end

	assign pin_o = level_q;

endmodule // ssmc_sync

/* rtl/ssmc_top.sv */
// ssmc_top: standby and stop mode controller of a 4-bit controller core.
// Assumes the CPU pulses the sleep and stop inputs once per executed
// instruction, and that interrupt flags and masks come from logic on the
// same clock. The shared port / halt release pad is asynchronous.
`timescale 1ns/1ns

// Functional notes
// - sleep instruction in active enters standby
// - standby keeps oscillator, gates instruction clocks only
// - standby holds registers, RAM and output levels
// - standby keeps peripherals clocked and running
// - reset pin low ends standby via reset
// - unmasked pending request wakes standby to active
// - wake resumes at instruction after sleep
// - global enable decides handler or pending continue
// - stop keeps RAM through either release source
// - retention only across reset that ends stop
// - stop released by reset or release pin
// - wake select bit routes shared pin function
// - wake select survives stop; others cleared
// - port function register write-only, 4 or 2 bits
// - retained flag set only by pin release
// - write zero clears flag; one ignored
// - reset clears retained flag
// - stop instruction halts oscillator and everything
// - release pin low resets, sets retained flag
// - release pin only in stop; reset always
// - sleep or stop cancelled when pending, disabled
module ssmc_top #(
	parameter logic REDUCED = 1'b0
) (
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     RSTN_I,
	input  wire logic                     CE_I,
	input  wire ssmc_pkg::ssmc_reg_req_t  REG_REQ_I,
	output logic [ssmc_pkg::NIB_W-1:0]    REG_RDATA_O,
	input  wire logic                     SLEEP_INSTR_I,
	input  wire logic                     STOP_INSTR_I,
	input  wire ssmc_pkg::ssmc_irq_t      IRQ_I,
	input  wire logic                     PAD_I,
	output logic                          PAD_O,
	output logic                          PAD_OE_O,
	input  wire logic                     PORT_BIT4_DO_I,
	input  wire logic                     PORT_BIT4_OE_I,
	output logic                          PORT_BIT4_DI_O,
	output logic [ssmc_pkg::NIB_W-1:0]    PORT_FUNC_O,
	output logic                          RAM_FLAG_O,
	output ssmc_pkg::ssmc_pwr_t           PWR_O,
	output ssmc_pkg::ssmc_state_t         MODE_O,
	output logic                          RESUME_O,
	output logic                          IRQ_TAKE_O,
	output logic                          INSTR_NOP_O
);
	import ssmc_pkg::*;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	ssmc_state_t      state_q;
	ssmc_state_t      state_d;
	ssmc_state_t      state_nxt;
	ssmc_pwr_t        pwr_q;
	logic             pin_s;
	logic             wake_sel;
	logic             pending;
	logic             cancel;
	logic             release_low;
	logic             stop_like;
	logic             stop_entry;
	logic             flag_set;
	logic [NIB_W-1:0] port_func;
	logic             ram_flag;
	logic             resume_q;
	logic             take_q;
	logic             nop_q;
	logic             pad_q;
	logic             pad_oe_q;
	logic             bit4_di_q;
	ssmc_pwr_t        pwr_d;

	// ------------------------------------------------------------------
	// shared pad synchroniser
	// ------------------------------------------------------------------

	// pad passes four flops before any use
	ssmc_sync u_pin_sync (
		.clk_i  (SYS_CLK_I),
		.rstn_i (RSTN_I),
		.ce_i   (CE_I),
		.pin_i  (PAD_I),
		.pin_o  (pin_s)
	);

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------

	// port function select and ram retained flag
	ssmc_regs u_regs (
		.clk_i        (SYS_CLK_I),
		.rstn_i       (RSTN_I),
		.ce_i         (CE_I),
		.reduced_i    (REDUCED),
		.req_i        (REG_REQ_I),
		.stop_entry_i (stop_entry),
		.flag_set_i   (flag_set),
		.port_func_o  (port_func),
		.ram_flag_o   (ram_flag),
		.rdata_o      (REG_RDATA_O)
	);

	// ------------------------------------------------------------------
	// wake and cancel conditions
	// ------------------------------------------------------------------

	// any source with flag set and mask clear
	assign pending  = |(IRQ_I.flag & ~IRQ_I.mask);

	// disabled but pending: the instruction becomes a no-op
	assign cancel   = pending && !IRQ_I.global_en;

	// shared pin only acts as halt release when selected
	assign wake_sel = port_func[WAKE_SEL_BIT];

	// release request is honoured only from the stop states
	assign release_low = wake_sel && !pin_s;

	// ------------------------------------------------------------------
	// retention classification
	// ------------------------------------------------------------------

	// states whose reset keeps the RAM guarantee
	always_comb begin
		case (state_q)
			ST_STOP:     stop_like = 1'b1;
			ST_STOP_REL: stop_like = 1'b1;
			ST_RST_KEEP: stop_like = 1'b1;
			default:     stop_like = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// mode sequencer, next state
	// ------------------------------------------------------------------

	// stop takes priority when both instructions arrive together
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_ACTIVE: begin
				if (STOP_INSTR_I && !cancel) begin
					state_d = ST_STOP;
				end else if (SLEEP_INSTR_I && !cancel) begin
					state_d = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (pending) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_STOP: begin
				if (release_low) begin
					state_d = ST_STOP_REL;
				end
			end
			ST_STOP_REL: begin
				if (!release_low) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_RST: begin
				state_d = ST_ACTIVE;
			end
			ST_RST_KEEP: begin
				state_d = ST_ACTIVE;
			end
			default: begin
				state_d = ST_RST;
			end
		endcase
	end

	// reset pin overrides every mode
	always_comb begin
		if (!RSTN_I) begin
			state_nxt = stop_like ? ST_RST_KEEP : ST_RST;
		end else begin
			state_nxt = state_d;
		end
	end

	// stop entry clears the lower port function bits
	assign stop_entry = RSTN_I && (state_q == ST_ACTIVE)
		&& (state_d == ST_STOP);

	// flag is set throughout release reset handling
	assign flag_set = state_q == ST_STOP_REL;

	// ------------------------------------------------------------------
	// mode sequencer, state register
	// ------------------------------------------------------------------

	// reset is synchronous; clock enable freezes everything
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			state_q <= state_nxt;
		end
	end

	// ------------------------------------------------------------------
	// power and clock control outputs
	// ------------------------------------------------------------------

	// decode of a mode into clock, reset and port controls
	function automatic ssmc_pwr_t pwr_of(input ssmc_state_t st);
		ssmc_pwr_t p;
		p = '0;
		case (st)
			ST_ACTIVE: begin
				p.osc_en        = 1'b1;
				p.cpu_clk_en    = 1'b1;
				p.periph_clk_en = 1'b1;
			end
			ST_STANDBY: begin
				p.osc_en        = 1'b1;
				p.periph_clk_en = 1'b1;
				p.port_hold     = 1'b1;
			end
			ST_STOP: begin
				p.cpu_rst       = 1'b1;
				p.periph_rst    = 1'b1;
				p.port_hiz      = 1'b1;
				p.ram_retain    = 1'b1;
			end
			ST_STOP_REL: begin
				p.osc_en        = 1'b1;
				p.cpu_rst       = 1'b1;
				p.periph_rst    = 1'b1;
				p.port_hiz      = 1'b1;
				p.ram_retain    = 1'b1;
			end
			ST_RST_KEEP: begin
				p.osc_en        = 1'b1;
				p.cpu_rst       = 1'b1;
				p.periph_rst    = 1'b1;
				p.port_hiz      = 1'b1;
				p.ram_retain    = 1'b1;
			end
			default: begin
				p.osc_en        = 1'b1;
				p.cpu_rst       = 1'b1;
				p.periph_rst    = 1'b1;
				p.port_hiz      = 1'b1;
			end
		endcase
		return p;
	endfunction

	// decoded controls of the mode about to be entered
	assign pwr_d = pwr_of(state_nxt);

	// controls are registered alongside the mode they belong to
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			pwr_q <= pwr_d;
		end
	end

	// ------------------------------------------------------------------
	// event pulses toward the CPU
	// ------------------------------------------------------------------

	// wake from standby resumes after the sleep instruction
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (!RSTN_I) begin
				resume_q <= 1'b0;
			end else begin
				resume_q <= (state_q == ST_STANDBY) && pending;
			end
		end
	end

	// handler runs only when globally enabled
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (!RSTN_I) begin
				take_q <= 1'b0;
			end else begin
				take_q <= (state_q == ST_STANDBY) && pending
					&& IRQ_I.global_en;
			end
		end
	end

	// cancelled sleep or stop is reported as a no-op
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (!RSTN_I) begin
				nop_q <= 1'b0;
			end else begin
				nop_q <= (state_q == ST_ACTIVE) && cancel
					&& (SLEEP_INSTR_I || STOP_INSTR_I);
			end
		end
	end

	// ------------------------------------------------------------------
	// shared pad routing
	// ------------------------------------------------------------------

	// port side drives the pad only in its own function
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (!RSTN_I) begin
				pad_q    <= 1'b0;
				pad_oe_q <= 1'b0;
			end else begin
				pad_q    <= PORT_BIT4_DO_I;
				pad_oe_q <= PORT_BIT4_OE_I && !wake_sel
					&& !pwr_d.port_hiz;
			end
		end
	end

	// port input sees idle level while pad is the release input
	always_ff @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (!RSTN_I) begin
				bit4_di_q <= PIN_IDLE;
			end else begin
				bit4_di_q <= wake_sel ? PIN_IDLE : pin_s;
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign PWR_O        = pwr_q;
	assign MODE_O       = state_q;
	assign RESUME_O     = resume_q;
	assign IRQ_TAKE_O   = take_q;
	assign INSTR_NOP_O  = nop_q;
	assign PAD_O          = pad_q;
	assign PAD_OE_O       = pad_oe_q;
	assign PORT_BIT4_DI_O = bit4_di_q;
	assign PORT_FUNC_O  = port_func;
	assign RAM_FLAG_O   = ram_flag;

endmodule // ssmc_top

/* test/ssmc_far_model.sv */
// ssmc_far_model: interrupt sources and the wake pad driver.
// Assumes the pad is pulled up, and pulled low by this model or driven by the port side.
`timescale 1ns/1ns
module ssmc_far_model #(
	parameter int HOLD = 8
) (
	input  wire logic                         clk_i,
	input  wire logic                         rstn_i,
	input  wire logic                         pad_go_i,
	input  wire logic [ssmc_pkg::IRQ_N-1:0]   flag_set_i,
	input  wire logic [ssmc_pkg::IRQ_N-1:0]   flag_clr_i,
	input  wire logic [ssmc_pkg::IRQ_N-1:0]   mask_i,
	input  wire logic                         ge_i,
	output logic                              pad_lo_o,
	output ssmc_pkg::ssmc_irq_t               irq_o
);
	import ssmc_pkg::*;
	int               cnt_q;
	logic [IRQ_N-1:0] flag_q;
	// pad held low through oscillator settling
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			cnt_q <= 0;
		else if (pad_go_i)
			cnt_q <= HOLD;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
	end
	assign pad_lo_o = (cnt_q > 0);
	// request flags set by sources, cleared by software
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			flag_q <= '0;
		else
			flag_q <= (flag_q & ~flag_clr_i) | flag_set_i;
	end
	assign irq_o = '{flag: flag_q, mask: mask_i, global_en: ge_i};
endmodule // ssmc_far_model

/* test/ssmc_top_sva.sv */
// ssmc_top_sva: port-level assertions of the low power mode controller.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module ssmc_chk (
	input wire logic                    SYS_CLK_I,
	input wire logic                    RSTN_I,
	input wire logic                    CE_I,
	input wire ssmc_pkg::ssmc_reg_req_t REG_REQ_I,
	input wire logic                    SLEEP_INSTR_I,
	input wire logic                    STOP_INSTR_I,
	input wire ssmc_pkg::ssmc_irq_t     IRQ_I,
	input wire logic                    PAD_OE_O,
	input wire logic                    PORT_BIT4_DI_O,
	input wire logic [3:0]              PORT_FUNC_O,
	input wire logic                    RAM_FLAG_O,
	input wire ssmc_pkg::ssmc_pwr_t     PWR_O,
	input wire ssmc_pkg::ssmc_state_t   MODE_O,
	input wire logic                    RESUME_O,
	input wire logic                    IRQ_TAKE_O,
	input wire logic                    INSTR_NOP_O
);
	import ssmc_pkg::*;
	logic pend;
	logic hold;
	// unmasked request pending, and the cancel condition
	assign pend = |(IRQ_I.flag & ~IRQ_I.mask);
	assign hold = pend && !IRQ_I.global_en;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I || !CE_I);
	// --------------------------------------------------------------
	// mode entry and exit
	// --------------------------------------------------------------
	property p_sleep;
		MODE_O == ST_ACTIVE && SLEEP_INSTR_I && !STOP_INSTR_I && !hold
			|=> MODE_O == ST_STANDBY;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no standby");
	property p_stop;
		MODE_O == ST_ACTIVE && STOP_INSTR_I && !hold |=> MODE_O == ST_STOP;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_nop;
		MODE_O == ST_ACTIVE && (SLEEP_INSTR_I || STOP_INSTR_I) && hold
			|=> INSTR_NOP_O && MODE_O == ST_ACTIVE;
	endproperty
	a_nop: assert property (p_nop) else $error("not cancelled");
	property p_wake;
		MODE_O == ST_STANDBY && pend |=> MODE_O == ST_ACTIVE && RESUME_O
			&& IRQ_TAKE_O == $past(IRQ_I.global_en);
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	// --------------------------------------------------------------
	// power controls, registers and pad routing
	// --------------------------------------------------------------
	property p_stby;
		MODE_O == ST_STANDBY |-> PWR_O.osc_en && !PWR_O.cpu_clk_en
			&& PWR_O.periph_clk_en && PWR_O.port_hold;
	endproperty
	a_stby: assert property (p_stby) else $error("stby pwr");
	property p_stp;
		MODE_O == ST_STOP |-> !PWR_O.osc_en && PWR_O.cpu_rst
			&& PWR_O.periph_rst && PWR_O.port_hiz && PWR_O.ram_retain;
	endproperty
	a_stp: assert property (p_stp) else $error("stop power");
	property p_keep;
		$rose(MODE_O == ST_STOP) |-> PORT_FUNC_O[2:0] == 3'h0 &&
			PORT_FUNC_O[WAKE_SEL_BIT] == $past(PORT_FUNC_O[WAKE_SEL_BIT]);
	endproperty
	a_keep: assert property (p_keep) else $error("port func at stop");
	property p_flag;
		$rose(RAM_FLAG_O) |-> $past(MODE_O) == ST_STOP_REL;
	endproperty
	a_flag: assert property (p_flag) else $error("flag source");
	property p_clr;
		MODE_O == ST_ACTIVE && REG_REQ_I.wr && REG_REQ_I.addr == ADDR_RAM_FLAG
			&& REG_REQ_I.wmask[RAM_FLAG_BIT] && !REG_REQ_I.wdata[RAM_FLAG_BIT]
			|=> !RAM_FLAG_O;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_sel;
		$past(PORT_FUNC_O[WAKE_SEL_BIT]) |-> !PAD_OE_O && PORT_BIT4_DI_O;
	endproperty
	a_sel: assert property (p_sel) else $error("pad routing");
	// main scenarios reached
	c_wake: cover property (MODE_O == ST_STANDBY ##1 RESUME_O);
	c_rel: cover property (MODE_O == ST_STOP_REL);
	c_nop: cover property (INSTR_NOP_O);
endmodule // ssmc_chk

bind ssmc_top ssmc_chk ssmc_chk_inst (.*);

/* test/standby_stop_mode_control_tb_top.sv */
// standby_stop_mode_control_tb_top: self-checking bench of ssmc_top.
// Assumes ssmc_far_model and the bound checker are compiled first.
`timescale 1ns/1ns
module standby_stop_mode_control_tb_top;
	import ssmc_pkg::*;
	// --------------------------------------------------------------
	// stimulus, observation and model state
	// --------------------------------------------------------------
	logic          clk    = 1'b0;
	logic          rstn   = 1'b0;
	logic          sleep  = 1'b0;
	logic          stop   = 1'b0;
	logic          pad_go = 1'b0;
	logic          pdo    = 1'b1;
	logic          ge     = 1'b0;
	logic [6:0]    fset   = 7'h00;
	logic [6:0]    fclr   = 7'h00;
	logic [6:0]    mask   = 7'h7F;
	ssmc_reg_req_t req    = '0;
	logic [3:0]    rdata, pfunc;
	logic          pad_lo, pad_w, pad_o, pad_oe, bit4_di;
	logic          flag, resume, take, nop;
	ssmc_irq_t     irq;
	ssmc_pwr_t     pwr;
	ssmc_state_t   mode;
	int            err_total = 0;
	int            checks_done = 0;
	int            exp_pf = 0;
	int            exp_flag = 0;
	int            exp_rd[$];
	int            b, v;
	// pad wire: model pulls low, else port drive when enabled, else pull-up
	assign pad_w = pad_lo ? 1'b0 : (pad_oe ? pad_o : PIN_IDLE);
	initial begin
		forever #25 clk = ~clk;
	end
	ssmc_top ssmc_top_inst (.SYS_CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1),
		.REG_REQ_I(req), .REG_RDATA_O(rdata), .SLEEP_INSTR_I(sleep),
		.STOP_INSTR_I(stop), .IRQ_I(irq), .PAD_I(pad_w), .PAD_O(pad_o),
		.PAD_OE_O(pad_oe), .PORT_BIT4_DO_I(pdo), .PORT_BIT4_OE_I(1'b1),
		.PORT_BIT4_DI_O(bit4_di), .PORT_FUNC_O(pfunc), .RAM_FLAG_O(flag),
		.PWR_O(pwr), .MODE_O(mode), .RESUME_O(resume), .IRQ_TAKE_O(take),
		.INSTR_NOP_O(nop));
	ssmc_far_model ssmc_far_model_inst (.clk_i(clk), .rstn_i(rstn),
		.pad_go_i(pad_go), .flag_set_i(fset), .flag_clr_i(fclr),
		.mask_i(mask), .ge_i(ge), .pad_lo_o(pad_lo), .irq_o(irq));
	// --------------------------------------------------------------
	// compare, drive and closing tasks
	// --------------------------------------------------------------
	task automatic chk(input string n, input logic [3:0] e,
		input logic [3:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_mode(input ssmc_state_t m);
		chk("mode", {1'b0, m}, {1'b0, mode});
	endtask
	task automatic chk_flag();
		chk("flag", exp_flag[3:0], {3'h0, flag});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [3:0] d, input logic [3:0] m);
		@(posedge clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d, wmask: m};
		@(posedge clk);
		req <= '0;
		#1;
		if (w && a == ADDR_PORT_FUNC)
			exp_pf = (exp_pf & ~m) | (d & m);
		if (w && a == ADDR_RAM_FLAG && m[3] && !d[3])
			exp_flag = 0;
	endtask
	task automatic rd(input logic [9:0] a);
		int e;
		exp_rd.push_back(a == ADDR_RAM_FLAG ? exp_flag * 8 : 0);
		bus(1'b0, a, 4'h0, 4'h0);
		e = exp_rd.pop_front();
		chk("rdata", e[3:0], rdata);
	endtask
	task automatic instr(input logic s);
		@(posedge clk);
		stop  <= s;
		sleep <= !s;
		@(posedge clk);
		stop  <= 1'b0;
		sleep <= 1'b0;
		#1;
	endtask
	task automatic pulse_pad();
		@(posedge clk);
		pad_go <= 1'b1;
		@(posedge clk);
		pad_go <= 1'b0;
	endtask
	task automatic clr_irq();
		@(posedge clk);
		fclr <= 7'h7F;
		@(posedge clk);
		fclr <= 7'h00;
	endtask
	task automatic wait_mode(input ssmc_state_t m);
		#1;
		for (int i = 0; i < 40 && mode !== m; i++) begin
			@(posedge clk);
			#1;
		end
		chk_mode(m);
		if (mode !== m)
			report_and_stop();
	endtask
	task automatic do_reset(input ssmc_state_t m);
		if (rstn) begin
			@(posedge clk);
			rstn <= 1'b0;
		end
		exp_pf = 0;
		exp_flag = 0;
		repeat (2) @(posedge clk);
		#1;
		chk_mode(m);
		chk_flag();
		chk("pfunc", 4'h0, pfunc);
		chk("retain", {3'h0, m == ST_RST_KEEP}, {3'h0, pwr.ram_retain});
		@(posedge clk);
		rstn <= 1'b1;
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		v = $urandom(32'h3A53);
		do_reset(ST_RST);
		rd(ADDR_RAM_FLAG);
		rd(ADDR_PORT_FUNC);
		rd(10'h3FF);
		v = $urandom % 8;
		@(posedge clk);
		pdo <= v[0];
		bus(1'b1, ADDR_PORT_FUNC, v[3:0], 4'hF);
		chk("pfunc", exp_pf[3:0], pfunc);
		rd(ADDR_PORT_FUNC);
		chk("pad route", {3'h1, v[0]}, {2'h0, pad_oe, pad_o});
		// standby woken by a random source, both enable settings
		for (int g = 0; g < 2; g++) begin
			b = $urandom % 7;
			@(posedge clk);
			ge   <= g[0];
			mask <= ~(7'h01 << b);
			instr(1'b0);
			chk_mode(ST_STANDBY);
			chk("stby pwr", 4'hB, {pwr.osc_en, pwr.cpu_clk_en,
				pwr.periph_clk_en, pwr.port_hold});
			repeat ($urandom % 4) @(posedge clk);
			@(posedge clk);
			fset <= 7'h01 << b;
			@(posedge clk);
			fset <= 7'h00;
			wait_mode(ST_ACTIVE);
			chk("wake", {2'h0, 1'b1, g[0]}, {2'h0, resume, take});
			clr_irq();
		end
		instr(1'b0);
		chk_mode(ST_STANDBY);
		do_reset(ST_RST);
		// pending request with global enable off cancels both
		@(posedge clk);
		fset <= 7'h01;
		mask <= 7'h7E;
		ge   <= 1'b0;
		@(posedge clk);
		fset <= 7'h00;
		for (int s = 0; s < 2; s++) begin
			instr(s[0]);
			chk("nop", 4'h1, {3'h0, nop});
			chk_mode(ST_ACTIVE);
		end
		clr_irq();
		// release pad ignored outside stop
		v = 8 + $urandom % 8;
		bus(1'b1, ADDR_PORT_FUNC, v[3:0], 4'hF);
		pulse_pad();
		repeat (12) @(posedge clk);
		#1;
		chk_mode(ST_ACTIVE);
		chk_flag();
		chk("pad route", 4'h1, {2'h0, pad_oe, bit4_di});
		// stop released by the pad
		instr(1'b1);
		exp_pf = exp_pf & 8;
		chk_mode(ST_STOP);
		chk("pfunc", exp_pf[3:0], pfunc);
		chk("stop pwr", 4'h7, {pwr.osc_en, pwr.cpu_rst, pwr.port_hiz,
			pwr.ram_retain});
		pulse_pad();
		wait_mode(ST_STOP_REL);
		wait_mode(ST_ACTIVE);
		exp_flag = 1;
		chk_flag();
		chk("pfunc", exp_pf[3:0], pfunc);
		rd(ADDR_RAM_FLAG);
		bus(1'b1, ADDR_RAM_FLAG, 4'h8, 4'h8);
		chk_flag();
		bus(1'b1, ADDR_RAM_FLAG, 4'h0, 4'h8);
		chk_flag();
		// stop released by the reset pin
		instr(1'b1);
		chk_mode(ST_STOP);
		do_reset(ST_RST_KEEP);
		report_and_stop();
	end
endmodule // standby_stop_mode_control_tb_top
